/* rtl/dsg_switch_point.sv */
// switch point generator: hysteresis window, digital dither, enhanced dither, output control
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_switch_point
   import dsg_pkg::*;
#(
   parameter int TIMEOUT_CYC = `DSG_ED_TIMEOUT_MS * `DSG_CLK_KHZ,
   parameter int AVG_W = 10
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`DSG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   input wire logic sense_high_input,
   input wire logic sense_low_input,
   output dsg_points_t points_q,
   output logic solenoid_output_q
);

   // ************************************************************
   // functions
   // ************************************************************

   function automatic logic [7:0] hyst_counts(input logic [2:0] code);
      logic [7:0] c;
      c = `DSG_HYST_C0;
      case (code)
         3'h0: c = `DSG_HYST_C0;
         3'h1: c = `DSG_HYST_C1;
         3'h2: c = `DSG_HYST_C2;
         3'h3: c = `DSG_HYST_C3;
         3'h4: c = `DSG_HYST_C4;
         3'h5: c = `DSG_HYST_C5;
         3'h6: c = `DSG_HYST_C6;
         3'h7: c = `DSG_HYST_C7;
         default: c = `DSG_HYST_C0;
      endcase
      return c;
   endfunction

   // one amplitude step is 12.5 mVpp, about 5.25 dac counts per side
   function automatic logic signed [11:0] dither_offset(input logic [4:0] amp,
                                                        input logic [3:0] tri_lvl);
      logic [11:0] half;
      logic [11:0] ramp;
      half = 12'({amp, 2'b00} + {2'b00, amp}) + 12'(amp >> 2);
      ramp = 12'((half * 2 * tri_lvl) >> `DSG_TRI_SHIFT);
      return $signed(ramp) - $signed(half);
   endfunction

   function automatic logic [9:0] clamp_dac(input logic signed [11:0] v);
      logic [9:0] r;
      r = v[9:0];
      if (v < 12'sh000) begin
         r = 10'h000;
      end else if (v > `DSG_DAC_MAX) begin
         r = 10'h3ff;
      end
      return r;
   endfunction

   // ************************************************************
   // registers
   // ************************************************************

   logic [AVG_W-1:0] avg_q;
   logic [2:0] hyst_q;
   dsg_dither_cfg_t dcfg_q;
   dsg_state_t state_q;
   logic [3:0] phase_q;
   logic crossed_q;
   logic [31:0] ext_cnt_q;
   logic high_meta_q, high_s_q, low_meta_q, low_s_q;
   logic step_tick;
   logic falling;
   logic [3:0] tri_lvl;
   logic signed [11:0] offset;
   logic signed [11:0] mid;
   logic signed [11:0] hw;
   logic period_end;
   logic timed_out;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avg_q <= `DSG_AVG_RST;
         hyst_q <= `DSG_HYST_RST;
         dcfg_q <= '{enhanced: 1'b0, freq: `DSG_FREQ_RST, amp: `DSG_AMP_RST};
      end else if (reg_wr) begin
         case (reg_addr)
            `DSG_OFF_AVG: avg_q <= reg_wdata[AVG_W-1:0];
            `DSG_OFF_HYST: hyst_q <= reg_wdata[2:0];
            `DSG_OFF_DITHER: begin
               dcfg_q.amp <= reg_wdata[`DSG_AMP_LSB +: `DSG_AMP_W];
               dcfg_q.freq <= reg_wdata[`DSG_FREQ_LSB +: `DSG_FREQ_W];
               dcfg_q.enhanced <= reg_wdata[`DSG_ENH_BIT];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `DSG_OFF_AVG: reg_rdata_q <= 32'(avg_q);
               `DSG_OFF_HYST: reg_rdata_q <= 32'(hyst_q);
               `DSG_OFF_DITHER: begin
                  reg_rdata_q[`DSG_AMP_LSB +: `DSG_AMP_W] <= dcfg_q.amp;
                  reg_rdata_q[`DSG_FREQ_LSB +: `DSG_FREQ_W] <= dcfg_q.freq;
                  reg_rdata_q[`DSG_ENH_BIT] <= dcfg_q.enhanced;
               end
               `DSG_OFF_STATUS: begin
                  reg_rdata_q[`DSG_ST_LOWER_LSB +: 10] <= points_q.lower;
                  reg_rdata_q[`DSG_ST_UPPER_LSB +: 10] <= points_q.upper;
                  reg_rdata_q[`DSG_ST_OUT_BIT] <= solenoid_output_q;
                  reg_rdata_q[`DSG_ST_EXT_BIT] <= (state_q == DSG_EXTEND);
                  reg_rdata_q[`DSG_ST_FALL_BIT] <= falling;
               end
               default: reg_rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // comparator synchronisers
   // ************************************************************

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         high_meta_q <= 1'b0;
         high_s_q <= 1'b0;
         low_meta_q <= 1'b0;
         low_s_q <= 1'b0;
      end else begin
         high_meta_q <= sense_high_input;
         high_s_q <= high_meta_q;
         low_meta_q <= sense_low_input;
         low_s_q <= low_meta_q;
      end
   end

   // ************************************************************
   // dither waveform
   // ************************************************************

   // step length scales with the frequency code
   dsg_step_timer #(
      .UNIT_CYC(`DSG_STEP_UNIT_NS / `DSG_CLK_PERIOD_NS),
      .DIV_W(`DSG_FREQ_W)
   ) u_step (
      .clk(clk),
      .sys_rst(sys_rst),
      .period_code(dcfg_q.freq),
      .tick_q(step_tick)
   );

   assign falling = (phase_q >= `DSG_PHASE_FALL);
   // rising 0..7, falling 8 down to 1, minimum again at phase 0
   assign tri_lvl = falling ? 4'(5'h10 - {1'b0, phase_q}) : phase_q;
   assign period_end = step_tick && (phase_q == `DSG_PHASE_LAST) && (state_q == DSG_RUN);
   assign timed_out = (ext_cnt_q >= 32'(TIMEOUT_CYC));

   always_comb begin
      offset = 12'sh000;
      // amplitude and frequency both zero give no offset
      if (dcfg_q.amp != '0 || dcfg_q.freq != '0) begin
         offset = dither_offset(dcfg_q.amp, tri_lvl);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= 4'h0;
      end else if (state_q == DSG_RUN && step_tick) begin
         phase_q <= phase_q + 4'h1;
      end
   end

   // ************************************************************
   // enhanced dither
   // ************************************************************

   // a crossing in the clearing cycle still counts for the decision
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         crossed_q <= 1'b0;
      end else if (period_end) begin
         crossed_q <= 1'b0;
      end else if (falling && low_s_q) begin
         crossed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= DSG_RUN;
      end else begin
         case (state_q)
            DSG_RUN: begin
               // extend only when the falling slope saw no crossing
               if (period_end && dcfg_q.enhanced && !crossed_q && !low_s_q) begin
                  state_q <= DSG_EXTEND;
               end
            end
            DSG_EXTEND: begin
               if (low_s_q || timed_out || !dcfg_q.enhanced) begin
                  state_q <= DSG_RUN;
               end
            end
            default: state_q <= DSG_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_cnt_q <= 32'h0000_0000;
      end else if (state_q == DSG_EXTEND) begin
         ext_cnt_q <= ext_cnt_q + 32'h0000_0001;
      end else begin
         ext_cnt_q <= 32'h0000_0000;
      end
   end

   // ************************************************************
   // switch points and output
   // ************************************************************

   // phase is 0 throughout the extension, holding the lowest lower point
   // midpoint is the command plus the dither offset
   assign mid = $signed(12'(avg_q)) + offset;
   assign hw = $signed(12'(hyst_counts(hyst_q)));

   // clamping only guards against wrap; range faults are handled elsewhere
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         points_q <= '{upper: 10'h000, lower: 10'h000};
      end else begin
         points_q.upper <= clamp_dac(mid + hw);
         points_q.lower <= clamp_dac(mid - hw);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         solenoid_output_q <= 1'b0;
      end else if (avg_q == '0) begin
         solenoid_output_q <= 1'b0;
      end else if (solenoid_output_q && high_s_q) begin
         solenoid_output_q <= 1'b0;
      end else if (!solenoid_output_q && low_s_q) begin
         solenoid_output_q <= 1'b1;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_off_at_upper: assert property (
      solenoid_output_q && high_s_q |=> !solenoid_output_q)
      else $error("output stayed on past upper point");

   a_on_at_lower: assert property (
      !solenoid_output_q && low_s_q && avg_q != '0 |=> solenoid_output_q)
      else $error("output stayed off past lower point");

   a_window_width: assert property (
      $stable(avg_q) && $stable(hyst_q) && $stable(offset) && avg_q > 10'h060
      && avg_q < 10'h380 && hyst_q == 3'h7 ##1 $stable(offset)
      |-> points_q.upper - points_q.lower == 10'd92)
      else $error("window width wrong for top code");

   a_mid_no_dither: assert property (
      dcfg_q.amp == '0 && dcfg_q.freq == '0 && avg_q > 10'h060 && avg_q < 10'h380
      && $stable(avg_q) |=> 11'(points_q.upper) + 11'(points_q.lower) == 11'({$past(avg_q), 1'b0}))
      else $error("midpoint differs from command");

   a_no_dither_zero: assert property (
      dcfg_q.amp == '0 && dcfg_q.freq == '0 |-> offset == 12'sh000)
      else $error("offset present with dither off");

   a_fixed_no_ext: assert property (
      !dcfg_q.enhanced && state_q == DSG_RUN ##1 !dcfg_q.enhanced |-> state_q == DSG_RUN)
      else $error("extension in fixed mode");

   a_ext_decision: assert property (
      period_end && dcfg_q.enhanced && (crossed_q || low_s_q) |=> state_q == DSG_RUN)
      else $error("period extended after crossing");

   a_ext_end_cross: assert property (
      state_q == DSG_EXTEND && low_s_q |=> state_q == DSG_RUN)
      else $error("extension not ended by crossing");

   a_ext_timeout: assert property (
      state_q == DSG_EXTEND |-> ext_cnt_q <= 32'(TIMEOUT_CYC))
      else $error("extension ran past timeout");

   a_ext_hold_min: assert property (
      state_q == DSG_EXTEND |-> phase_q == 4'h0 && tri_lvl == 4'h0)
      else $error("lower point not held at minimum");

   c_extend: cover property (period_end ##1 state_q == DSG_EXTEND);
   c_timeout: cover property (state_q == DSG_EXTEND && timed_out);
   c_toggle: cover property (solenoid_output_q ##[1:50] !solenoid_output_q);

endmodule

/* rtl/dsg_regs.svh */
// register offsets, field positions and timing constants of the switch point generator
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// register offsets (byte addresses)
`define DSG_ADDR_W 8
`define DSG_OFF_AVG 8'h00
`define DSG_OFF_HYST 8'h04
`define DSG_OFF_DITHER 8'h08
`define DSG_OFF_STATUS 8'h0c

// dither configuration fields
`define DSG_AMP_LSB 0
`define DSG_AMP_W 5
`define DSG_FREQ_LSB 8
`define DSG_FREQ_W 7
`define DSG_ENH_BIT 16

// status fields
`define DSG_ST_LOWER_LSB 0
`define DSG_ST_UPPER_LSB 10
`define DSG_ST_OUT_BIT 20
`define DSG_ST_EXT_BIT 21
`define DSG_ST_FALL_BIT 22

// reset values
`define DSG_AVG_RST 10'h000
`define DSG_HYST_RST 3'h0
`define DSG_AMP_RST 5'h00
`define DSG_FREQ_RST 7'h00

// half-window in dac counts per hysteresis code
`define DSG_HYST_C0 8'h11
`define DSG_HYST_C1 8'h15
`define DSG_HYST_C2 8'h19
`define DSG_HYST_C3 8'h1d
`define DSG_HYST_C4 8'h21
`define DSG_HYST_C5 8'h25
`define DSG_HYST_C6 8'h2a
`define DSG_HYST_C7 8'h2e

// dither waveform: 16 steps per period, rising half first
`define DSG_PHASE_LAST 4'hf
`define DSG_PHASE_FALL 4'h8
`define DSG_TRI_SHIFT 3
`define DSG_DAC_MAX 12'sh3ff

// timing
`define DSG_CLK_PERIOD_NS 20
`define DSG_STEP_UNIT_NS 12000
`define DSG_ED_TIMEOUT_MS 15
`define DSG_CLK_KHZ 50000

`endif

/* rtl/dsg_pkg.sv */
// types shared by the switch point generator
package dsg_pkg;

   typedef struct packed {
      logic [9:0] upper;
      logic [9:0] lower;
   } dsg_points_t;

   typedef struct packed {
      logic enhanced;
      logic [6:0] freq;
      logic [4:0] amp;
   } dsg_dither_cfg_t;

   typedef enum logic [1:0] {
      DSG_RUN = 2'b00,
      DSG_EXTEND = 2'b01
   } dsg_state_t;

endpackage

/* rtl/dsg_step_timer.sv */
// dither step timer: one tick per dither step, step length set by the frequency code
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_step_timer #(
   parameter int UNIT_CYC = `DSG_STEP_UNIT_NS / `DSG_CLK_PERIOD_NS,
   parameter int DIV_W = `DSG_FREQ_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [DIV_W-1:0] period_code,
   output logic tick_q
);

   logic [15:0] unit_q;
   logic [DIV_W-1:0] div_q;
   logic unit_end;

   assign unit_end = (unit_q == 16'(UNIT_CYC - 1));

   // a zero code never ticks, which freezes the waveform where it is
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         unit_q <= 16'h0000;
      end else if (unit_end || period_code == '0) begin
         unit_q <= 16'h0000;
      end else begin
         unit_q <= unit_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (period_code == '0) begin
            div_q <= '0;
         end else if (unit_end) begin
            if (div_q >= period_code - 1'b1) begin
               div_q <= '0;
               tick_q <= 1'b1;
            end else begin
               div_q <= div_q + 1'b1;
            end
         end
      end
   end

endmodule

/* bench/dsg_solenoid_model.sv */
// solenoid coil and current-sense comparators facing the switch point generator
`timescale 1ns/1ps
module dsg_solenoid_model
   import dsg_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic solenoid_output_q,
   input wire dsg_points_t points_q,
   input wire logic [3:0] rise_step,
   input wire logic [3:0] fall_step,
   output logic sense_high_input,
   output logic sense_low_input,
   output logic [10:0] level_q
);
   // coil current in dac counts; per-cycle slew stands in for inductance and supply
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= 11'h000;
      end else if (solenoid_output_q) begin
         level_q <= level_q + 11'(rise_step);
      end else if (level_q > 11'(fall_step)) begin
         level_q <= level_q - 11'(fall_step);
      end else begin
         level_q <= 11'h000;
      end
   end
   // bare level detectors: the device owns synchronising
   assign sense_high_input = level_q >= {1'b0, points_q.upper};
   assign sense_low_input = level_q <= {1'b0, points_q.lower};
endmodule

/* bench/testbench.sv */
// self-checking bench for the switch point generator
`timescale 1ns/1ps
`include "dsg_regs.svh"
module testbench;
   import dsg_pkg::*;
   localparam int TMO = 200;
   logic clk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata_q;
   logic sense_high_input;
   logic sense_low_input;
   dsg_points_t points_q;
   logic solenoid_output_q;
   logic [3:0] rise_step;
   logic [3:0] fall_step;
   logic [10:0] level_q;
   int n_fail;
   int check_count;
   int hw[8] = '{17, 21, 25, 29, 33, 37, 42, 46};

   dsg_switch_point #(.TIMEOUT_CYC(TMO)) dsg_switch_point_inst (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .sense_high_input(sense_high_input),
      .sense_low_input(sense_low_input), .points_q(points_q),
      .solenoid_output_q(solenoid_output_q));
   dsg_solenoid_model dsg_solenoid_model_inst (.clk(clk), .sys_rst(sys_rst),
      .solenoid_output_q(solenoid_output_q), .points_q(points_q), .rise_step(rise_step),
      .fall_step(fall_step), .sense_high_input(sense_high_input),
      .sense_low_input(sense_low_input), .level_q(level_q));

   // ************************************************
   // bus and compare helpers
   // ************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   function automatic int mid2();
      return int'(points_q.upper) + int'(points_q.lower);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset();
      logic [31:0] d;
      tick(2);
      chk(32'(points_q), {12'h0, 10'd17, 10'd0}, "points after reset");
      chk(32'(solenoid_output_q), 0, "output with zero command");
      wr(8'h20, 32'h0000_03ff);
      wr(`DSG_OFF_STATUS, 32'hffff_ffff);
      rd(8'h20, d);
      chk(d, 0, "unmapped read");
      rd(`DSG_OFF_STATUS, d);
      chk(32'(d[19:0]), 32'h0000_4400, "status after reset");
   endtask
   task automatic t_hyst();
      logic [31:0] d;
      int mv;
      wr(`DSG_OFF_AVG, 32'h0000_0200);
      for (int c = 0; c < 8; c++) begin
         wr(`DSG_OFF_HYST, 32'(c));
         tick(3);
         chk(32'(points_q.upper), 32'(512 + hw[c]), "upper point");
         chk(32'(points_q.lower), 32'(512 - hw[c]), "lower point");
         chk(32'(mid2()), 32'd1024, "window midpoint");
         mv = (int'(points_q.upper) - int'(points_q.lower)) * 1230 / 1024;
         // the fixed dac counts land within a couple of mv of each 10 mv step
         chk(32'(mv >= 38 + 10 * c && mv <= 42 + 10 * c), 1, "window in mv");
         rd(`DSG_OFF_STATUS, d);
         chk(32'(d[9:0]), 32'(512 - hw[c]), "status lower");
      end
   endtask
   task automatic t_regulate();
      int ons = 0;
      int bad = 0;
      logic prev;
      tick(400);
      prev = solenoid_output_q;
      repeat (3000) begin
         tick(1);
         if (solenoid_output_q === 1'b1 && prev === 1'b0) ons++;
         prev = solenoid_output_q;
         if (level_q > 11'(points_q.upper) + 11'd16) bad++;
         if (level_q + 11'd16 < 11'(points_q.lower)) bad++;
      end
      chk(32'(ons > 10), 1, "output keeps switching");
      chk(32'(bad), 0, "current leaves window");
   endtask
   task automatic t_dither();
      int lo = 4096;
      int hi = 0;
      int bad = 0;
      int s0;
      // dither and extension expectations below assume the 66 count window of code 4
      wr(`DSG_OFF_HYST, 32'h0000_0004);
      // frequency code stays nonzero whenever amplitude is nonzero
      wr(`DSG_OFF_DITHER, 32'h0000_0108);
      tick(10);
      repeat (9600) begin
         tick(1);
         if (int'(points_q.upper) - int'(points_q.lower) != 66) bad++;
         if (mid2() < lo) lo = mid2();
         if (mid2() > hi) hi = mid2();
      end
      chk(32'(bad), 0, "window width under dither");
      chk(32'(lo), 32'(2 * (512 - 42)), "dither trough");
      chk(32'(hi), 32'(2 * (512 + 42)), "dither crest");
      s0 = mid2();
      tick(9600);
      chk(32'(mid2()), 32'(s0), "dither period");
      wr(`DSG_OFF_DITHER, 32'h0);
      tick(5);
      chk(32'(mid2()), 32'd1024, "dither off");
      tick(1200);
      chk(32'(mid2()), 32'd1024, "dither stays off");
   endtask
   task automatic t_enh_normal();
      logic [31:0] d;
      int seen = 0;
      wr(`DSG_OFF_DITHER, 32'h0001_0108);
      repeat (5000) begin
         rd(`DSG_OFF_STATUS, d);
         if (d[21] !== 1'b0) seen++;
      end
      chk(32'(seen), 0, "extension despite crossing");
   endtask
   // waits for an extension, then sets the coil decay and times the extension in reads
   task automatic ext_run(input logic [3:0] fs, output int n, output int bad);
      logic [31:0] d;
      int k = 0;
      n = 0;
      bad = 0;
      d = 32'h0;
      while (d[21] !== 1'b1 && k < 12000) begin
         rd(`DSG_OFF_STATUS, d);
         k++;
      end
      fall_step <= fs;
      while (d[21] === 1'b1 && n < 1000) begin
         // points trail the state by one cycle, so the first extended read may lag
         if (n > 0 && d[9:0] !== 10'(512 - 33 - 42)) bad++;
         n++;
         rd(`DSG_OFF_STATUS, d);
      end
   endtask
   task automatic t_extend();
      int n;
      int bad;
      fall_step <= 4'd0;
      ext_run(4'd0, n, bad);
      chk(32'(n >= TMO / 2 - 2 && n <= TMO / 2 + 3), 1, "extension timeout");
      chk(32'(bad), 0, "lower held while extended");
      ext_run(4'd8, n, bad);
      chk(32'(n >= 1 && n <= 25), 1, "extension ends on crossing");
   endtask

   // ************************************************
   // clock, reset, sequence and watchdog
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      $display("wrong value at %0t: watchdog expired", $time);
      summarize();
   end
   initial begin
      n_fail = 0;
      check_count = 0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rise_step = 4'd3;
      fall_step = 4'd2;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_hyst();
      t_regulate();
      t_dither();
      t_enh_normal();
      t_extend();
      summarize();
   end
endmodule
